// ===== lps_consts.svh
// Purpose: Named offsets, fields, resets and timings of the sensor link
// Assumes: 50 MHz system clock on both ends
// Notes: Definitions only
`ifndef LPS_CONSTS_SVH
`define LPS_CONSTS_SVH

`define DEV_ADDR 7'h44
`define OFS_RSVD 8'h00
`define OFS_CFG 8'h01
`define OFS_EVT 8'h02
`define OFS_NLO 8'h03
`define OFS_NHI 8'h04
`define OFS_LLO 8'h05
`define OFS_LMID 8'h06
`define OFS_LHI 8'h07

`define RST_CFG 8'h00
`define RST_EVT 8'h00
`define RST_NLO 8'h00
`define RST_NHI 8'hFF
`define RST_LLO 8'h00
`define RST_LMID 8'hF0
`define RST_LHI 8'hFF

`define CFG_NEAR_EN 7
`define CFG_SLP_HI 6
`define CFG_SLP_LO 4
`define CFG_DRIVE 3
`define CFG_LIGHT_EN 2
`define CFG_RANGE 1
`define CFG_SPECTRUM 0
`define EVT_NEAR_FLAG 7
`define EVT_NPRST_HI 6
`define EVT_NPRST_LO 5
`define EVT_UNUSED 4
`define EVT_LIGHT_FLAG 3
`define EVT_LPRST_HI 2
`define EVT_LPRST_LO 1
`define EVT_AND_MODE 0

`define PERSIST_0 5'h01
`define PERSIST_1 5'h04
`define PERSIST_2 5'h08
`define PERSIST_3 5'h10

`define CLK_PERIOD_NS 20
`define NEAR_CONV_NS 540000
`define TICK_NS 100000
`define LINK_QTR_NS 625
`define LIGHT_PERIOD_TICKS 14'h03E8
`define SLP_111_TICKS 14'h0000
`define SLP_110_TICKS 14'h007D
`define SLP_101_TICKS 14'h01F4
`define SLP_100_TICKS 14'h02EE
`define SLP_011_TICKS 14'h03E8
`define SLP_010_TICKS 14'h07D0
`define SLP_001_TICKS 14'h0FA0
`define SLP_000_TICKS 14'h1F40

`define HOST_OFS_CMD 32'h0000_0000
`define HOST_OFS_WDATA 32'h0000_0004
`define HOST_OFS_STAT 32'h0000_0008
`define HOST_CMD_READ 8
`define HOST_STAT_BUSY 8
`define HOST_STAT_NACK 9
`define HTRANS_NONSEQ 2'h2

`endif

// ===== lps_pkg.sv
// Purpose: Shared types of the sensor link ends
// Assumes: Nothing
// Notes: State codes are one-hot
package lps_pkg;
  typedef enum logic [4:0] {
    DS_IDLE = 5'h01,
    DS_RX = 5'h02,
    DS_ACK = 5'h04,
    DS_TX = 5'h08,
    DS_MACK = 5'h10
  } dev_state_e;

  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_START = 4'h2,
    HS_BITS = 4'h4,
    HS_STOP = 4'h8
  } host_state_e;
endpackage

// ===== lps_link_if.sv
// Purpose: Two-wire link between host master and sensor register bank
// Assumes: Open-drain data line with pull-up, clock driven by host only
// Notes: Resolves the data line from both output enables
`timescale 1ns/10ps
interface lps_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe;
  logic dev_sda_out;
  logic dev_sda_oe;
  logic sda;

  // Pull-up wins unless a driver sinks the line
  assign sda = (host_sda_oe && !host_sda_out) || (dev_sda_oe && !dev_sda_out)
               ? 1'b0 : 1'b1;

  modport host (output scl, output host_sda_out, output host_sda_oe,
                input sda);
  modport dev (input scl, output dev_sda_out, output dev_sda_oe, input sda);
endinterface

// ===== lps_sensor_regs.sv
// Purpose: Sensor configuration and event register bank on the two-wire link
// Assumes: Link pins synchronous to clk_sys; samples come from converters
// Notes: Data registers and test registers are not part of this bank
`timescale 1ns/10ps
`include "lps_consts.svh"

// What this block does
// [RQ1] Config bit 7 runs proximity; first result after 0.54ms
// [RQ2] Bits 6:4 choose idle time between LED pulses
// [RQ3] Bit 3 picks 110mA or 220mA LED sink
// [RQ4] Bit 2 runs light conversion every 100ms
// [RQ5] Bit 1 picks low or high lux range
// [RQ6] Bit 0 picks visible or infrared result
// [RQ7] Event bit 7 sticky proximity flag, clear by 0
// [RQ8] Bits 6:5 proximity persistence 1/4/8/16
// [RQ9] Host writes zero to event bit 4
// [RQ10] Event bit 3 sticky light flag, clear by 0
// [RQ11] Bits 2:1 light persistence 1/4/8/16
// [RQ12] Bit 0 chooses OR or AND onto interrupt
// [RQ13] Offset 03 proximity low limit, reset zero
// [RQ14] Offset 04 proximity high limit, reset ones
// [RQ15] Offset 05 light low limit lower byte
// [RQ16] Offset 00 reserved, no defined contents
// [RQ17] Offsets 06/07 hold remaining light limits
// [RQ18] Link slave address fixed at 1000100
// [RQ19] Persistence counts restart on miss or disable
// [RQ20] Writing one to a flag changes nothing
module lps_sensor_regs #(
  parameter int NEAR_CONV_CYCLES = `NEAR_CONV_NS / `CLK_PERIOD_NS,
  parameter int TICK_CYCLES = `TICK_NS / `CLK_PERIOD_NS
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  lps_link_if.dev link, // Two-wire link
  input wire logic near_sample_valid, // Proximity result strobe
  input wire logic [7:0] near_sample, // Proximity result
  input wire logic light_sample_valid, // Light result strobe
  input wire logic [11:0] light_sample, // Light or IR result
  output logic near_convert_start, // Starts a proximity conversion
  output logic light_convert_start, // Starts a light conversion
  output logic near_result_ready, // First proximity result is due
  output logic near_sense_on, // Proximity enabled
  output logic [2:0] near_idle_period, // Sleep code
  output logic led_drive_strength, // High for 220mA pulses
  output logic light_sense_on, // Light enabled
  output logic light_range_sel, // High-lux range
  output logic light_spectrum_sel, // Infrared readings
  output logic int_n // Interrupt, active low
);
  lps_pkg::dev_state_e state;
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;
  logic [7:0] shreg;
  logic [3:0] bcnt;
  logic first_byte;
  logic have_ptr;
  logic rd_mode;
  logic mnack;
  logic [7:0] ptr;
  logic [7:0] rd_val;
  logic byte_done;
  logic addr_hit;
  logic wr_en;
  logic [7:0] cfg;
  logic [7:0] evt;
  logic [7:0] near_lo;
  logic [7:0] near_hi;
  logic [7:0] light_lo_lsb;
  logic [7:0] light_mid;
  logic [7:0] light_hi_msb;
  logic [11:0] light_lo;
  logic [11:0] light_hi;
  logic [1:0] ch_valid;
  logic [1:0] ch_trip;
  logic [1:0] ch_en;
  logic [1:0] ch_hit;
  logic [1:0] psel [2];
  logic [4:0] pcnt [2];
  logic [15:0] tick_cnt;
  logic tick;
  logic near_active;
  logic near_sleeping;
  logic [15:0] conv_cnt;
  logic [13:0] sleep_left;
  logic [13:0] sleep_ticks;
  logic light_active;
  logic [13:0] light_ticks;

  assign scl_rise = link.scl && !scl_q;
  assign scl_fall = !link.scl && scl_q;
  assign start_seen = link.scl && scl_q && sda_q && !link.sda;
  assign stop_seen = link.scl && scl_q && !sda_q && link.sda;
  assign byte_done = state == lps_pkg::DS_RX && scl_fall && bcnt == 4'h8;
  assign addr_hit = shreg[7:1] == `DEV_ADDR; // [RQ18]
  assign wr_en = byte_done && !first_byte && have_ptr;
  assign link.dev_sda_out = 1'b0;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= link.scl;
      sda_q <= link.sda;
    end
  end

  // Reserved and unmapped offsets read as zero
  always_comb begin
    case (ptr)
      `OFS_CFG: rd_val = cfg;
      `OFS_EVT: rd_val = evt;
      `OFS_NLO: rd_val = near_lo;
      `OFS_NHI: rd_val = near_hi;
      `OFS_LLO: rd_val = light_lo_lsb;
      `OFS_LMID: rd_val = light_mid;
      `OFS_LHI: rd_val = light_hi_msb;
      default: rd_val = 8'h00; // [RQ16]
    endcase
  end

  // Link slave: address, pointer, then data bytes with auto-increment
  always_ff @(posedge clk_sys) begin
    if (reset || stop_seen) begin
      state <= lps_pkg::DS_IDLE;
      link.dev_sda_oe <= 1'b0;
      bcnt <= 4'h0;
      shreg <= 8'h00;
      first_byte <= 1'b0;
      have_ptr <= 1'b0;
      rd_mode <= 1'b0;
      mnack <= 1'b0;
      ptr <= 8'h00;
    end else if (start_seen) begin
      state <= lps_pkg::DS_RX;
      link.dev_sda_oe <= 1'b0;
      bcnt <= 4'h0;
      first_byte <= 1'b1;
    end else begin
      case (state)
        lps_pkg::DS_RX: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], link.sda};
            bcnt <= bcnt + 4'h1;
          end else if (byte_done) begin
            first_byte <= 1'b0;
            if (first_byte && !addr_hit) begin
              state <= lps_pkg::DS_IDLE;
            end else begin
              state <= lps_pkg::DS_ACK;
              link.dev_sda_oe <= 1'b1;
              if (first_byte) begin
                rd_mode <= shreg[0];
              end else if (!have_ptr) begin
                ptr <= shreg;
                have_ptr <= 1'b1;
              end else begin
                ptr <= ptr + 8'h01;
              end
            end
          end
        end
        lps_pkg::DS_ACK: begin
          if (scl_fall) begin
            bcnt <= 4'h1;
            if (rd_mode) begin
              state <= lps_pkg::DS_TX;
              shreg <= rd_val;
              link.dev_sda_oe <= !rd_val[7];
              ptr <= ptr + 8'h01;
            end else begin
              state <= lps_pkg::DS_RX;
              link.dev_sda_oe <= 1'b0;
              bcnt <= 4'h0;
            end
          end
        end
        lps_pkg::DS_TX: begin
          if (scl_fall) begin
            if (bcnt == 4'h8) begin
              state <= lps_pkg::DS_MACK;
              link.dev_sda_oe <= 1'b0;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              link.dev_sda_oe <= !shreg[6];
              bcnt <= bcnt + 4'h1;
            end
          end
        end
        lps_pkg::DS_MACK: begin
          if (scl_rise) begin
            mnack <= link.sda;
          end else if (scl_fall) begin
            if (mnack) begin
              state <= lps_pkg::DS_IDLE;
            end else begin
              state <= lps_pkg::DS_TX;
              shreg <= rd_val;
              link.dev_sda_oe <= !rd_val[7];
              bcnt <= 4'h1;
              ptr <= ptr + 8'h01;
            end
          end
        end
        default: begin
          state <= lps_pkg::DS_IDLE;
          link.dev_sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // Plain read/write registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cfg <= `RST_CFG;
      near_lo <= `RST_NLO; // [RQ13]
      near_hi <= `RST_NHI; // [RQ14]
      light_lo_lsb <= `RST_LLO; // [RQ15]
      light_mid <= `RST_LMID; // [RQ17]
      light_hi_msb <= `RST_LHI; // [RQ17]
    end else if (wr_en) begin
      case (ptr)
        `OFS_CFG: cfg <= shreg;
        `OFS_NLO: near_lo <= shreg; // [RQ13]
        `OFS_NHI: near_hi <= shreg; // [RQ14]
        `OFS_LLO: light_lo_lsb <= shreg; // [RQ15]
        `OFS_LMID: light_mid <= shreg; // [RQ17]
        `OFS_LHI: light_hi_msb <= shreg; // [RQ17]
        default: cfg <= cfg;
      endcase
    end
  end

  assign light_lo = {light_mid[3:0], light_lo_lsb};
  assign light_hi = {light_hi_msb, light_mid[7:4]};
  assign ch_valid = {light_sample_valid, near_sample_valid};
  assign ch_en = {cfg[`CFG_LIGHT_EN], cfg[`CFG_NEAR_EN]};
  assign ch_trip[0] = near_sample > near_hi || near_sample < near_lo;
  assign ch_trip[1] = light_sample > light_hi || light_sample < light_lo;
  assign psel[0] = evt[`EVT_NPRST_HI:`EVT_NPRST_LO];
  assign psel[1] = evt[`EVT_LPRST_HI:`EVT_LPRST_LO];

  // Persistence per channel: consecutive tripping results
  for (genvar c = 0; c < 2; c++) begin : g_persist
    logic [4:0] target;
    always_comb begin
      case (psel[c])
        2'h0: target = `PERSIST_0; // [RQ8] [RQ11]
        2'h1: target = `PERSIST_1;
        2'h2: target = `PERSIST_2;
        default: target = `PERSIST_3;
      endcase
    end
    assign ch_hit[c] = ch_en[c] && ch_valid[c] && ch_trip[c]
                       && (pcnt[c] + 5'h01 >= target);
    always_ff @(posedge clk_sys) begin
      if (reset || !ch_en[c]) begin
        pcnt[c] <= 5'h00; // [RQ19]
      end else if (ch_valid[c]) begin
        if (!ch_trip[c]) begin
          pcnt[c] <= 5'h00; // [RQ19]
        end else if (pcnt[c] < target) begin
          pcnt[c] <= pcnt[c] + 5'h01;
        end
      end
    end
  end

  // Event register: a new event beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      evt <= `RST_EVT;
    end else begin
      if (ch_hit[0]) begin
        evt[`EVT_NEAR_FLAG] <= 1'b1; // [RQ7]
      end else if (wr_en && ptr == `OFS_EVT && !shreg[`EVT_NEAR_FLAG]) begin
        evt[`EVT_NEAR_FLAG] <= 1'b0; // [RQ7] [RQ20]
      end
      if (ch_hit[1]) begin
        evt[`EVT_LIGHT_FLAG] <= 1'b1; // [RQ10]
      end else if (wr_en && ptr == `OFS_EVT && !shreg[`EVT_LIGHT_FLAG]) begin
        evt[`EVT_LIGHT_FLAG] <= 1'b0; // [RQ10] [RQ20]
      end
      if (wr_en && ptr == `OFS_EVT) begin
        evt[`EVT_NPRST_HI:`EVT_NPRST_LO] <=
          shreg[`EVT_NPRST_HI:`EVT_NPRST_LO]; // [RQ8]
        evt[`EVT_LPRST_HI:`EVT_LPRST_LO] <=
          shreg[`EVT_LPRST_HI:`EVT_LPRST_LO]; // [RQ11]
        evt[`EVT_AND_MODE] <= shreg[`EVT_AND_MODE]; // [RQ12]
        evt[`EVT_UNUSED] <= 1'b0; // [RQ9]
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      int_n <= 1'b1;
    end else if (evt[`EVT_AND_MODE]) begin
      int_n <= !(evt[`EVT_NEAR_FLAG] && evt[`EVT_LIGHT_FLAG]); // [RQ12]
    end else begin
      int_n <= !(evt[`EVT_NEAR_FLAG] || evt[`EVT_LIGHT_FLAG]); // [RQ12]
    end
  end

  assign near_sense_on = cfg[`CFG_NEAR_EN]; // [RQ1]
  assign near_idle_period = cfg[`CFG_SLP_HI:`CFG_SLP_LO]; // [RQ2]
  assign led_drive_strength = cfg[`CFG_DRIVE]; // [RQ3]
  assign light_sense_on = cfg[`CFG_LIGHT_EN]; // [RQ4]
  assign light_range_sel = cfg[`CFG_RANGE]; // [RQ5]
  assign light_spectrum_sel = cfg[`CFG_SPECTRUM]; // [RQ6]

  // Shared 0.1ms tick keeps the long sleep counters narrow
  always_ff @(posedge clk_sys) begin
    if (reset || tick) begin
      tick_cnt <= 16'h0000;
    end else begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end
  assign tick = tick_cnt == 16'(TICK_CYCLES - 1);

  always_comb begin
    case (cfg[`CFG_SLP_HI:`CFG_SLP_LO])
      3'h7: sleep_ticks = `SLP_111_TICKS; // [RQ2]
      3'h6: sleep_ticks = `SLP_110_TICKS;
      3'h5: sleep_ticks = `SLP_101_TICKS;
      3'h4: sleep_ticks = `SLP_100_TICKS;
      3'h3: sleep_ticks = `SLP_011_TICKS;
      3'h2: sleep_ticks = `SLP_010_TICKS;
      3'h1: sleep_ticks = `SLP_001_TICKS;
      default: sleep_ticks = `SLP_000_TICKS;
    endcase
  end

  // Proximity scheduler: convert, then sleep, then convert again
  always_ff @(posedge clk_sys) begin
    if (reset || !cfg[`CFG_NEAR_EN]) begin
      near_active <= 1'b0;
      near_sleeping <= 1'b0;
      near_convert_start <= 1'b0;
      near_result_ready <= 1'b0;
      conv_cnt <= 16'h0000;
      sleep_left <= 14'h0000;
    end else begin
      near_convert_start <= 1'b0;
      if (!near_active || (near_sleeping && sleep_left == 14'h0000)) begin
        near_active <= 1'b1;
        near_sleeping <= 1'b0;
        near_convert_start <= 1'b1; // [RQ1]
        conv_cnt <= 16'h0000;
      end else if (!near_sleeping) begin
        conv_cnt <= conv_cnt + 16'h0001;
        if (conv_cnt == 16'(NEAR_CONV_CYCLES - 1)) begin
          near_result_ready <= 1'b1; // [RQ1]
          near_sleeping <= 1'b1;
          sleep_left <= sleep_ticks; // [RQ2]
        end
      end else if (tick) begin
        sleep_left <= sleep_left - 14'h0001;
      end
    end
  end

  // Light scheduler: a new conversion every 100ms while enabled
  always_ff @(posedge clk_sys) begin
    if (reset || !cfg[`CFG_LIGHT_EN]) begin
      light_active <= 1'b0;
      light_convert_start <= 1'b0;
      light_ticks <= 14'h0000;
    end else begin
      light_convert_start <= 1'b0;
      if (!light_active || light_ticks == `LIGHT_PERIOD_TICKS) begin
        light_active <= 1'b1;
        light_convert_start <= 1'b1; // [RQ4]
        light_ticks <= 14'h0000;
      end else if (tick) begin
        light_ticks <= light_ticks + 14'h0001;
      end
    end
  end
endmodule

// ===== lps_link_host.sv
// Purpose: Host end: AHB-Lite command registers driving the two-wire master
// Assumes: Single device on the link, zero-wait-state AHB-Lite slave
// Notes: One register access per command; reads use a repeated start
`timescale 1ns/10ps
`include "lps_consts.svh"

module lps_link_host #(
  parameter int QTR_CYCLES = (`LINK_QTR_NS + `CLK_PERIOD_NS - 1)
                             / `CLK_PERIOD_NS
) (
  input wire logic clk_sys, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size, word only
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB bus ready
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // Always ready
  output logic hresp, // Always OKAY
  lps_link_if.host link // Two-wire link
);
  lps_pkg::host_state_e state;
  logic ap_write;
  logic [31:0] ap_addr;
  logic launch;
  logic [7:0] reg_idx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic do_read;
  logic nack;
  logic [7:0] qcnt;
  logic qtick;
  logic [1:0] ph;
  logic [2:0] step;
  logic [3:0] bcnt;
  logic [7:0] tx;
  logic rx_byte;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign link.host_sda_out = 1'b0;
  assign launch = ap_write && ap_addr == `HOST_OFS_CMD
                  && state == lps_pkg::HS_IDLE;
  assign qtick = qcnt == 8'(QTR_CYCLES - 1);
  assign rx_byte = step == 3'h5;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ap_write <= 1'b0;
      ap_addr <= 32'h0000_0000;
      hrdata <= 32'h0000_0000;
    end else begin
      ap_write <= 1'b0;
      if (hready && hsel && htrans == `HTRANS_NONSEQ) begin
        ap_write <= hwrite;
        ap_addr <= haddr;
        case (haddr)
          `HOST_OFS_CMD: hrdata <= {23'h0, do_read, reg_idx};
          `HOST_OFS_WDATA: hrdata <= {24'h0, wbyte};
          `HOST_OFS_STAT: hrdata <= {22'h0, nack,
                                     state != lps_pkg::HS_IDLE, rbyte};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Commands written while busy are dropped
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      reg_idx <= 8'h00;
      do_read <= 1'b0;
      wbyte <= 8'h00;
    end else if (launch) begin
      reg_idx <= hwdata[7:0];
      do_read <= hwdata[`HOST_CMD_READ];
    end else if (ap_write && ap_addr == `HOST_OFS_WDATA) begin
      wbyte <= hwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || state == lps_pkg::HS_IDLE || qtick) begin
      qcnt <= 8'h00;
    end else begin
      qcnt <= qcnt + 8'h01;
    end
  end

  // Step 0 start, 1 address+W, 2 index, 3 data or restart,
  // 4 address+R, 5 read byte; stop is the HS_STOP state, step unchanged
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state <= lps_pkg::HS_IDLE;
      link.scl <= 1'b1;
      link.host_sda_oe <= 1'b0;
      ph <= 2'h0;
      step <= 3'h0;
      bcnt <= 4'h0;
      tx <= 8'h00;
      rbyte <= 8'h00;
      nack <= 1'b0;
    end else if (state == lps_pkg::HS_IDLE) begin
      if (launch) begin
        state <= lps_pkg::HS_START;
        step <= 3'h0;
        ph <= 2'h0;
        nack <= 1'b0;
      end
    end else if (qtick) begin
      ph <= ph + 2'h1;
      case (state)
        lps_pkg::HS_START: begin
          case (ph)
            2'h0: begin
              link.scl <= 1'b0;
              link.host_sda_oe <= 1'b0;
            end
            2'h1: link.scl <= 1'b1;
            2'h2: link.host_sda_oe <= 1'b1;
            default: begin
              link.scl <= 1'b0;
              state <= lps_pkg::HS_BITS;
              step <= step + 3'h1;
              bcnt <= 4'h0;
              tx <= {`DEV_ADDR, step != 3'h0};
            end
          endcase
        end
        lps_pkg::HS_BITS: begin
          case (ph)
            2'h0: begin
              if (bcnt == 4'h8) begin
                link.host_sda_oe <= 1'b0;
              end else begin
                link.host_sda_oe <= !rx_byte && !tx[7];
              end
            end
            2'h1: link.scl <= 1'b1;
            2'h2: begin
              if (bcnt == 4'h8) begin
                nack <= !rx_byte && link.sda;
              end else begin
                rbyte <= {rbyte[6:0], link.sda};
              end
            end
            default: begin
              link.scl <= 1'b0;
              tx <= {tx[6:0], 1'b0};
              bcnt <= bcnt + 4'h1;
              if (bcnt == 4'h8) begin
                bcnt <= 4'h0;
                if (nack || rx_byte || (step == 3'h3 && !do_read)) begin
                  state <= lps_pkg::HS_STOP;
                end else if (step == 3'h2 && do_read) begin
                  // Restart must land on the read address step
                  state <= lps_pkg::HS_START;
                  step <= 3'h3;
                end else begin
                  step <= step + 3'h1;
                  tx <= step == 3'h1 ? reg_idx : wbyte;
                end
              end
            end
          endcase
        end
        lps_pkg::HS_STOP: begin
          case (ph)
            2'h0: link.host_sda_oe <= 1'b1;
            2'h1: link.scl <= 1'b1;
            2'h2: link.host_sda_oe <= 1'b0;
            default: state <= lps_pkg::HS_IDLE;
          endcase
        end
        default: state <= lps_pkg::HS_IDLE;
      endcase
    end
  end
endmodule

// ===== lps_checker.sv
// Purpose: Link-level checks between host and device ends
// Assumes: QTR_CYCLES of 4 on the host
// Notes: Sees interface signals only
`timescale 1ns/10ps
module lps_checker (
  input wire logic clk_sys, // Clock
  input wire logic reset, // Reset
  input wire logic scl, // Link clock
  input wire logic host_sda_out, // Host level
  input wire logic host_sda_oe, // Host sinks
  input wire logic dev_sda_out, // Device level
  input wire logic dev_sda_oe, // Device sinks
  input wire logic sda // Line
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_high;
    scl [*4];
  endsequence
  sequence s_low;
    !scl [*4];
  endsequence
  a_host_open_drain: assert property (host_sda_oe |-> !host_sda_out)
    else $error("host drives high");
  a_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_out)
    else $error("device drives high");
  a_dev_sink_low: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device sank sda in scl high");
  a_idle_after_reset: assert property ($fell(reset) |->
    scl && !host_sda_oe && !dev_sda_oe) else $error("link busy");
  a_scl_high_hold: assert property ($rose(scl) |-> s_high)
    else $error("scl high too short");
  a_scl_low_hold: assert property ($fell(scl) |-> s_low)
    else $error("scl low too short");
  // Device moving data in scl high would fake a start or stop
  a_dev_steady_high: assert property (scl && $past(scl) |->
    $stable(dev_sda_oe)) else $error("device moved data");
  a_dev_release: assert property ($rose(dev_sda_oe) |->
    ##[1:200] !dev_sda_oe) else $error("device holds data");
endmodule

// ===== light_prox_config_interrupt_regs_tb_top.sv
// Purpose: Host-to-device register link bench
// Assumes: Shortened counts and quarter period of 4
// Notes: Random values from a fixed seed
`timescale 1ns/10ps
`include "lps_consts.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %0t %h %h", $time, a, e); end end
module light_prox_config_interrupt_regs_tb_top;
  logic clk_sys = 0, reset = 1, hsel = 0, hwrite = 0;
  logic near_v = 0, light_v = 0, hready, int_n, nrr, ch, ncs, lcs;
  logic [1:0] htrans = 0, pc;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rw;
  logic [7:0] near_s = 0, rd, v, ev, a, cfg;
  logic [11:0] light_s = 0, s_out, s_in;
  int n, fails = 0, n_tests = 0, seed = 32'h369b818f;
  logic [7:0] rst_v[8] = '{8'h00, `RST_CFG, `RST_EVT, `RST_NLO,
    `RST_NHI, `RST_LLO, `RST_LMID, `RST_LHI};
  lps_link_if link();
  lps_link_host #(.QTR_CYCLES(4)) lps_link_host_inst (.clk_sys, .reset,
    .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
    .hrdata, .hreadyout(hready), .hresp(), .link(link.host));
  lps_sensor_regs #(.NEAR_CONV_CYCLES(20), .TICK_CYCLES(4))
    lps_sensor_regs_inst (.clk_sys, .reset, .link(link.dev),
    .near_sample_valid(near_v), .near_sample(near_s),
    .light_sample_valid(light_v), .light_sample(light_s),
    .near_convert_start(ncs), .light_convert_start(lcs),
    .near_result_ready(nrr), .near_sense_on(cfg[7]),
    .near_idle_period(cfg[6:4]), .led_drive_strength(cfg[3]),
    .light_sense_on(cfg[2]), .light_range_sel(cfg[1]),
    .light_spectrum_sel(cfg[0]), .int_n);
  lps_checker lps_checker_inst (.clk_sys, .reset, .scl(link.scl),
    .host_sda_out(link.host_sda_out), .host_sda_oe(link.host_sda_oe),
    .dev_sda_out(link.dev_sda_out), .dev_sda_oe(link.dev_sda_oe),
    .sda(link.sda));
  initial forever #10 clk_sys = ~clk_sys;
  function automatic int persist(input logic [1:0] c);
    return c == 0 ? 1 : 4 << (c - 1);
  endfunction
  task automatic ahb(input logic w, input logic [31:0] ad, d);
    hsel <= 1;
    htrans <= `HTRANS_NONSEQ;
    haddr <= ad;
    hwrite <= w;
    do @(posedge clk_sys); while (hready !== 1'b1);
    htrans <= 0;
    hwdata <= d;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rw = hrdata;
  endtask
  task automatic wait_idle;
    int t;
    t = 0;
    do begin
      ahb(0, `HOST_OFS_STAT, 0);
      t++;
    end while (rw[`HOST_STAT_BUSY] !== 1'b0 && t < 999);
    rd = rw[7:0];
    `CHK(rw[`HOST_STAT_BUSY], 1'b0)
    `CHK(rw[`HOST_STAT_NACK], 1'b0)
  endtask
  task automatic dev_wr(input logic [7:0] idx, d);
    ahb(1, `HOST_OFS_WDATA, {24'h0, d});
    ahb(1, `HOST_OFS_CMD, {24'h0, idx});
    wait_idle();
  endtask
  task automatic dev_rd(input logic [7:0] idx);
    ahb(1, `HOST_OFS_CMD, {24'h1, idx});
    wait_idle();
  endtask
  task automatic pulse(input logic c, input int k, input logic [11:0] s);
    repeat (k) begin
      near_s <= s[7:0];
      light_s <= s;
      near_v <= !c;
      light_v <= c;
      @(posedge clk_sys);
      near_v <= 0;
      light_v <= 0;
      @(posedge clk_sys);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #1800000;
    fails++;
    tally_and_finish;
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    reset <= 0;
    @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      dev_rd(8'(i));
      `CHK(rd, rst_v[i])
    end
    for (int i = 0; i < 14; i++) begin
      v = 8'($random(seed));
      v[6:4] = 3'(i);
      a = i < 8 ? `OFS_CFG : 8'(i % 3 + 3);
      dev_wr(a, v);
      dev_rd(a);
      `CHK(rd, v)
      if (i < 8) `CHK(cfg, v)
    end
    dev_wr(`OFS_CFG, 8'h00);
    `CHK(nrr, 1'b0)
    // Time the first result from the conversion start it follows
    fork
      dev_wr(`OFS_CFG, 8'hF4);
      begin
        @(posedge clk_sys iff ncs);
        n = 0;
        do begin
          @(posedge clk_sys);
          n++;
        end while (nrr !== 1'b1 && n < 99);
      end
    join
    `CHK(n, 20)
    `CHK(nrr, 1'b1)
    // First light period depends on tick phase, so time the next one
    @(posedge clk_sys iff lcs);
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (lcs !== 1'b1 && n < 9999);
    `CHK(n, 4 * `LIGHT_PERIOD_TICKS)
    dev_wr(`OFS_NLO, 8'h10);
    dev_wr(`OFS_NHI, 8'h20);
    dev_wr(`OFS_LLO, 8'h50);
    for (int k = 0; k < 8; k++) begin
      ch = k[2];
      pc = k[1:0];
      ev = ch ? {5'h0, pc, 1'b0} : {1'b0, pc, 5'h0};
      s_out = ch ? 12'h010 : 12'h030;
      s_in = ch ? 12'h100 : 12'h018;
      n = persist(pc) - 1;
      dev_wr(`OFS_EVT, ev);
      // Leading in-window sample drops any saturated count
      repeat (2) begin
        pulse(ch, 1, s_in);
        pulse(ch, n, s_out);
      end
      dev_rd(`OFS_EVT);
      `CHK(rd, ev)
      `CHK(int_n, 1'b1)
      pulse(ch, 1, s_out);
      dev_rd(`OFS_EVT);
      `CHK(rd, ev | (ch ? 8'h08 : 8'h80))
      `CHK(int_n, 1'b0)
    end
    pulse(0, 1, 12'h018);
    dev_wr(`OFS_EVT, 8'h89);
    dev_rd(`OFS_EVT);
    `CHK(rd, 8'h09)
    `CHK(int_n, 1'b1)
    pulse(0, 1, 12'h030);
    dev_rd(`OFS_EVT);
    `CHK(rd, 8'h89)
    `CHK(int_n, 1'b0)
    dev_wr(`OFS_EVT, 8'h00);
    `CHK(int_n, 1'b1)
    tally_and_finish;
  end
endmodule
